// >>> src/smw_top.sv
// module: manageability watchdog with axi4-lite registers and smbus alert
`timescale 1ns/100ps
module smw_top (
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        intruder_n_in,
  input  wire logic        thermal_in,
  input  wire logic        first_fetch_in,
  input  wire logic [4:0]  func_decode_in,
  input  wire logic [4:0]  func_irq_in,
  input  wire logic [4:0]  func_pme_in,
  output logic [4:0]       func_decode_en_out,
  output logic [4:0]       func_irq_out,
  output logic [4:0]       func_pme_out,
  output logic             mgmt_interrupt_n_out,
  output logic             sys_reset_out,
  output logic             irq_out,
  input  wire logic        smb_scl_in,
  input  wire logic        smb_sda_in,
  output logic             smb_scl_out,
  output logic             smb_scl_oe_out,
  output logic             smb_sda_out,
  output logic             smb_sda_oe_out
);
  // ----------------------------------------------------------------
  // registers and synchronisers
  // ----------------------------------------------------------------
  logic [31:0]              ctrl_reg;
  logic [31:0]              reload_reg;
  logic [31:0]              count_reg;
  logic [31:0]              boot_reg;
  logic [31:0]              boot_cnt_reg;
  logic [7:0]               alert_reg;
  logic [smw_pkg::FDIS_W-1:0] fdis_reg;
  logic [smw_pkg::ST_W-1:0] stat_reg;
  logic [smw_pkg::ST_W-1:0] ien_reg;
  logic                     first_reg;
  logic                     booted_reg;
  logic [1:0]               intr_sync_reg;
  logic [1:0]               therm_sync_reg;
  logic [1:0]               fetch_sync_reg;
  logic [1:0]               sda_sync_reg;
  logic [1:0]               scl_sync_reg;
  logic                     intr_prev_reg;
  logic                     therm_prev_reg;
  logic                     mev_pend_reg;
  logic                     aw_hold_reg;
  logic                     w_hold_reg;
  logic [7:0]               aw_addr_reg;
  logic [31:0]              w_data_reg;
  logic [3:0]               w_strb_reg;
  logic                     wr_go;
  logic                     kick;
  logic                     expire;
  logic                     intr_rise;
  logic                     therm_rise;
  logic                     boot_fail;
  logic                     mev;
  logic [smw_pkg::ST_W-1:0] ev_set;
  logic [smw_pkg::ST_W-1:0] clr_mask;
  logic                     tx_start;
  logic                     tx_busy;
  logic                     tx_done;
  logic                     scl_oe;
  logic                     sda_oe;

  function automatic logic [31:0] merge(input logic [31:0] old_val,
                                        input logic [31:0] new_val,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[i*8 +: 8] = new_val[i*8 +: 8];
    end
    return res;
  endfunction : merge

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      intr_sync_reg  <= 2'b11;
      therm_sync_reg <= 2'b00;
      fetch_sync_reg <= 2'b00;
      sda_sync_reg   <= 2'b11;
      scl_sync_reg   <= 2'b11;
      intr_prev_reg  <= 1'b0;
      therm_prev_reg <= 1'b0;
    end else begin
      intr_sync_reg  <= {intr_sync_reg[0], intruder_n_in};
      therm_sync_reg <= {therm_sync_reg[0], thermal_in};
      fetch_sync_reg <= {fetch_sync_reg[0], first_fetch_in};
      sda_sync_reg   <= {sda_sync_reg[0], smb_sda_in};
      scl_sync_reg   <= {scl_sync_reg[0], smb_scl_in};
      intr_prev_reg  <= ~intr_sync_reg[1];
      therm_prev_reg <= therm_sync_reg[1];
    end
  end
  assign intr_rise  = ~intr_sync_reg[1] & ~intr_prev_reg;
  assign therm_rise = therm_sync_reg[1] & ~therm_prev_reg;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  assign wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= smw_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg <= smw_pkg::ALERT_OFS && aw_addr_reg[1:0] == 2'b00) ?
                        smw_pkg::RESP_OKAY : smw_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign kick     = wr_go && aw_addr_reg == smw_pkg::KICK_OFS && w_data_reg == smw_pkg::KICK_KEY;
  assign clr_mask = (wr_go && aw_addr_reg == smw_pkg::CLR_OFS) ?
                    w_data_reg[smw_pkg::ST_W-1:0] : '0;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_reg   <= smw_pkg::CTRL_RST;
      reload_reg <= smw_pkg::RELOAD_RST;
      boot_reg   <= smw_pkg::BOOT_RST;
      alert_reg  <= smw_pkg::ALERT_RST;
      fdis_reg   <= '0;
      ien_reg    <= '0;
    end else if (wr_go) begin
      case (aw_addr_reg)
        smw_pkg::CTRL_OFS:   ctrl_reg   <= merge(ctrl_reg, w_data_reg, w_strb_reg);
        smw_pkg::RELOAD_OFS: reload_reg <= merge(reload_reg, w_data_reg, w_strb_reg);
        smw_pkg::BOOT_OFS:   boot_reg   <= merge(boot_reg, w_data_reg, w_strb_reg);
        smw_pkg::ALERT_OFS:  if (w_strb_reg[0]) alert_reg <= w_data_reg[7:0];
        smw_pkg::FDIS_OFS:   if (w_strb_reg[0]) fdis_reg <= w_data_reg[smw_pkg::FDIS_W-1:0];
        smw_pkg::IEN_OFS:    if (w_strb_reg[0]) ien_reg <= w_data_reg[smw_pkg::ST_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // two-stage lock-up timer
  // ----------------------------------------------------------------
  assign expire = ctrl_reg[smw_pkg::CTRL_TMR_EN] && count_reg == 32'h0000_0000;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      count_reg <= smw_pkg::RELOAD_RST;
      first_reg <= 1'b0;
    end else if (kick || !ctrl_reg[smw_pkg::CTRL_TMR_EN]) begin
      count_reg <= reload_reg;
      first_reg <= 1'b0;
    end else if (expire) begin
      count_reg <= reload_reg;
      first_reg <= 1'b1;
    end else begin
      count_reg <= count_reg - 32'h0000_0001;
    end
  end
  AST_FIRST_SMI: assert property (@(posedge clk_in) disable iff (reset_in)
    expire && !first_reg && !kick |=> ##1 !mgmt_interrupt_n_out)
    else $error("first expiry raised no management interrupt");
  AST_SECOND_RST: assert property (@(posedge clk_in) disable iff (reset_in)
    expire && first_reg && !kick |=> sys_reset_out)
    else $error("second expiry did not reset system");
  AST_RELOAD: assert property (@(posedge clk_in) disable iff (reset_in)
    kick |=> count_reg == $past(reload_reg) && !first_reg)
    else $error("reload did not restart timer");

  // ----------------------------------------------------------------
  // first-fetch watch
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      booted_reg   <= 1'b0;
      boot_cnt_reg <= 32'h0000_0000;
    end else if (fetch_sync_reg[1]) begin
      booted_reg <= 1'b1;
    end else if (boot_fail) begin
      booted_reg <= 1'b1;  // one reboot request per reset
    end else if (!booted_reg && boot_cnt_reg != boot_reg) begin
      boot_cnt_reg <= boot_cnt_reg + 32'h0000_0001;
    end
  end
  assign boot_fail = ctrl_reg[smw_pkg::CTRL_BOOT_EN] && !booted_reg &&
                     !fetch_sync_reg[1] && boot_cnt_reg == boot_reg;
  AST_BOOT_REBOOT: assert property (@(posedge clk_in) disable iff (reset_in)
    boot_fail |=> sys_reset_out)
    else $error("missing first fetch did not reboot");

  // ----------------------------------------------------------------
  // events, status, interrupt, system outputs
  // ----------------------------------------------------------------
  assign mev = (intr_rise && ctrl_reg[smw_pkg::CTRL_INTR_SEL]) || therm_rise || boot_fail;
  always_comb begin
    ev_set = '0;
    ev_set[smw_pkg::ST_FIRST]      = expire && !first_reg && !kick;
    ev_set[smw_pkg::ST_SECOND]     = expire && first_reg && !kick;
    ev_set[smw_pkg::ST_INTRUDE]    = intr_rise;
    ev_set[smw_pkg::ST_THERMAL]    = therm_rise;
    ev_set[smw_pkg::ST_BOOTFAIL]   = boot_fail;
    ev_set[smw_pkg::ST_ALERT_DONE] = tx_done;
  end
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      stat_reg             <= '0;
      irq_out              <= 1'b0;
      mgmt_interrupt_n_out <= 1'b1;
      sys_reset_out        <= 1'b0;
    end else begin
      stat_reg <= (stat_reg & ~clr_mask) | ev_set;  // set wins over clear
      irq_out  <= |(stat_reg & ien_reg);
      mgmt_interrupt_n_out <= !(stat_reg[smw_pkg::ST_FIRST] ||
                              (stat_reg[smw_pkg::ST_INTRUDE] &&
                               !ctrl_reg[smw_pkg::CTRL_INTR_SEL]));
      sys_reset_out <= (expire && first_reg && !kick) || boot_fail;
    end
  end
  AST_INTR_SMI: assert property (@(posedge clk_in) disable iff (reset_in)
    intr_rise && !ctrl_reg[smw_pkg::CTRL_INTR_SEL] |=> ##1 !mgmt_interrupt_n_out)
    else $error("intrusion did not raise management interrupt");

  // ----------------------------------------------------------------
  // function disable gating
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      func_decode_en_out <= '0;
      func_irq_out       <= '0;
      func_pme_out       <= '0;
    end else begin
      func_decode_en_out <= func_decode_in & ~fdis_reg;
      func_irq_out       <= func_irq_in & ~fdis_reg;
      func_pme_out       <= func_pme_in & ~fdis_reg;
    end
  end
  AST_FDIS: assert property (@(posedge clk_in) disable iff (reset_in)
    fdis_reg[0] && $stable(fdis_reg) |=> !func_decode_en_out[0] && !func_irq_out[0])
    else $error("disabled function still active");

  // ----------------------------------------------------------------
  // alert message over smbus
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) mev_pend_reg <= 1'b0;
    else if (mev) mev_pend_reg <= 1'b1;
    else if (tx_start) mev_pend_reg <= 1'b0;
  end
  assign tx_start = mev_pend_reg && !tx_busy && !fdis_reg[smw_pkg::FDIS_SMBUS];
  AST_ALERT: assert property (@(posedge clk_in) disable iff (reset_in)
    tx_start |=> tx_busy)
    else $error("alert transmit did not start");

  smw_alert_tx u_tx (
    .clk_in     (clk_in),
    .reset_in   (reset_in),
    .start_in   (tx_start),
    .code_in    (alert_reg),
    .sda_in     (sda_sync_reg[1]),
    .scl_oe_out (scl_oe),
    .sda_oe_out (sda_oe),
    .busy_out   (tx_busy),
    .done_out   (tx_done)
  );
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      smb_scl_oe_out <= 1'b0;
      smb_sda_oe_out <= 1'b0;
      smb_scl_out    <= 1'b0;
      smb_sda_out    <= 1'b0;
    end else begin
      smb_scl_oe_out <= scl_oe;
      smb_sda_oe_out <= sda_oe;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= smw_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= smw_pkg::RESP_OKAY;
        case (s_axi_araddr)
          smw_pkg::CTRL_OFS:   s_axi_rdata <= ctrl_reg;
          smw_pkg::RELOAD_OFS: s_axi_rdata <= reload_reg;
          smw_pkg::COUNT_OFS:  s_axi_rdata <= count_reg;
          smw_pkg::FDIS_OFS:   s_axi_rdata <= 32'(fdis_reg);
          smw_pkg::STAT_OFS:   s_axi_rdata <= 32'(stat_reg);
          smw_pkg::IEN_OFS:    s_axi_rdata <= 32'(ien_reg);
          smw_pkg::BOOT_OFS:   s_axi_rdata <= boot_reg;
          smw_pkg::ALERT_OFS:  s_axi_rdata <= 32'(alert_reg);
          smw_pkg::KICK_OFS, smw_pkg::CLR_OFS: s_axi_rdata <= 32'h0000_0000;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= smw_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : smw_top

// >>> src/smw_pkg.sv
// package: register map, fields and timing for the manageability watchdog
package smw_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] RELOAD_OFS   = 8'h04;
  localparam logic [7:0] KICK_OFS     = 8'h08;
  localparam logic [7:0] COUNT_OFS    = 8'h0C;
  localparam logic [7:0] FDIS_OFS     = 8'h10;
  localparam logic [7:0] STAT_OFS     = 8'h14;
  localparam logic [7:0] CLR_OFS      = 8'h18;
  localparam logic [7:0] IEN_OFS      = 8'h1C;
  localparam logic [7:0] BOOT_OFS     = 8'h20;
  localparam logic [7:0] ALERT_OFS    = 8'h24;
  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int CTRL_TMR_EN    = 0;
  localparam int CTRL_INTR_SEL  = 1;  // 1: intrusion -> manageability event
  localparam int CTRL_BOOT_EN   = 2;
  localparam int FDIS_W         = 5;  // modem, audio, disk, usb, smbus
  localparam int FDIS_SMBUS     = 4;
  localparam int ST_W           = 6;
  localparam int ST_FIRST       = 0;
  localparam int ST_SECOND      = 1;
  localparam int ST_INTRUDE     = 2;
  localparam int ST_THERMAL     = 3;
  localparam int ST_BOOTFAIL    = 4;
  localparam int ST_ALERT_DONE  = 5;
  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RST     = 32'h0000_0004;
  localparam logic [31:0] RELOAD_RST   = 32'h0000_FFFF;
  localparam logic [31:0] BOOT_RST     = 32'h0001_0000;
  localparam logic [7:0]  ALERT_RST    = 8'hA5;
  localparam logic [31:0] KICK_KEY     = 32'h0000_5A5A;
  localparam int          CLK_MHZ      = 100;
  localparam int          SCL_KHZ      = 100;
  localparam int          SCL_QTR      = (CLK_MHZ * 1000) / (SCL_KHZ * 4);
  localparam logic [6:0]  ALERT_ADDR   = 7'h10;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;
endpackage : smw_pkg

// >>> src/smw_alert_tx.sv
// module: fixed alert message transmitter, smbus master write
`timescale 1ns/100ps
module smw_alert_tx (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       start_in,
  input  wire logic [7:0] code_in,
  input  wire logic       sda_in,
  output logic            scl_oe_out,
  output logic            sda_oe_out,
  output logic            busy_out,
  output logic            done_out
);
  typedef enum {TX_IDLE, TX_START, TX_BITS, TX_ACK, TX_STOP} smw_tx_e;
  smw_tx_e     state_reg;
  logic [15:0] div_reg;
  logic [1:0]  phase_reg;
  logic [3:0]  bit_reg;
  logic        byte_reg;
  logic [7:0]  shift_reg;
  logic        tick;
  // ----------------------------------------------------------------
  // quarter-bit enable
  // ----------------------------------------------------------------
  assign tick = (div_reg == 16'(smw_pkg::SCL_QTR - 1));
  always_ff @(posedge clk_in) begin
    if (reset_in || state_reg == TX_IDLE || tick) div_reg <= 16'h0000;
    else div_reg <= div_reg + 16'h0001;
  end
  // ----------------------------------------------------------------
  // frame: start, address+w, code byte, stop; open drain oe=drive low
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    done_out <= 1'b0;
    if (reset_in) begin
      state_reg  <= TX_IDLE;
      scl_oe_out <= 1'b0;
      sda_oe_out <= 1'b0;
      phase_reg  <= 2'd0;
      bit_reg    <= 4'd0;
      byte_reg   <= 1'b0;
      shift_reg  <= 8'h00;
      busy_out   <= 1'b0;
    end else begin
      case (state_reg)
        TX_IDLE: begin
          if (start_in) begin
            state_reg <= TX_START;
            busy_out  <= 1'b1;
            shift_reg <= {smw_pkg::ALERT_ADDR, 1'b0};
            byte_reg  <= 1'b0;
            phase_reg <= 2'd0;
          end
        end
        TX_START: if (tick) begin
          sda_oe_out <= 1'b1;
          phase_reg  <= phase_reg + 2'd1;
          if (phase_reg == 2'd1) begin
            scl_oe_out <= 1'b1;
            state_reg  <= TX_BITS;
            bit_reg    <= 4'd0;
            phase_reg  <= 2'd0;
          end
        end
        TX_BITS, TX_ACK: if (tick) begin
          phase_reg <= phase_reg + 2'd1;
          case (phase_reg)
            2'd0: sda_oe_out <= (state_reg == TX_ACK) ? 1'b0 : ~shift_reg[7];
            2'd1: scl_oe_out <= 1'b0;
            2'd2: scl_oe_out <= 1'b0;
            default: begin
              scl_oe_out <= 1'b1;
              if (state_reg == TX_ACK) begin
                if (byte_reg || sda_in) state_reg <= TX_STOP;
                else begin
                  state_reg <= TX_BITS;
                  shift_reg <= code_in;
                  byte_reg  <= 1'b1;
                  bit_reg   <= 4'd0;
                end
              end else begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                bit_reg   <= bit_reg + 4'd1;
                if (bit_reg == 4'd7) state_reg <= TX_ACK;
              end
            end
          endcase
        end
        TX_STOP: if (tick) begin
          phase_reg <= phase_reg + 2'd1;
          case (phase_reg)
            2'd0: sda_oe_out <= 1'b1;
            2'd1: scl_oe_out <= 1'b0;
            2'd2: sda_oe_out <= 1'b0;
            default: begin
              state_reg <= TX_IDLE;
              busy_out  <= 1'b0;
              done_out  <= 1'b1;
            end
          endcase
        end
        default: state_reg <= TX_IDLE;
      endcase
    end
  end
endmodule : smw_alert_tx

// >>> sim/smw_lan_model.sv
// model: lan controller that acknowledges and records one smbus alert write
`timescale 1ns/100ps
module smw_lan_model (
  input  wire logic  scl_in,
  input  wire logic  sda_in,
  output logic       ack_oe_out,
  output logic [7:0] addr_out,
  output logic [7:0] data_out,
  output int         nbytes_out
);
  logic [7:0] shift_reg;
  int         bits = 0;
  initial ack_oe_out = 1'b0;
  initial nbytes_out = 0;
  // start condition restarts the frame
  always @(negedge sda_in) if (scl_in === 1'b1) begin
    bits = 0;
    nbytes_out = 0;
  end
  always @(posedge scl_in) if (bits < 8) begin
    shift_reg = {shift_reg[6:0], sda_in};
    bits++;
  end
  // ack each byte, then release so the pull-up lifts the line
  always @(negedge scl_in) begin
    if (ack_oe_out) begin
      ack_oe_out <= 1'b0;
      bits = 0;
    end else if (bits == 8) begin
      ack_oe_out <= 1'b1;
      if (nbytes_out == 0) addr_out <= shift_reg;
      else data_out <= shift_reg;
      nbytes_out++;
    end
  end
endmodule : smw_lan_model

// >>> sim/test_system_manageability_watchdog.sv
// testbench: watchdog registers, timer, boot watch, alert and function gating
`timescale 1ns/100ps
module test_system_manageability_watchdog;
  logic clk_in = 0, reset_in = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, intruder_n_in = 1, thermal_in = 0;
  logic first_fetch_in = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, mgmt_interrupt_n_out, sys_reset_out, irq_out, smb_scl_in, smb_sda_in;
  logic smb_scl_out, smb_scl_oe_out, smb_sda_out, smb_sda_oe_out, ack_oe;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, lan_addr, lan_data;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, q, v, seed = 32'hEA646E14;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [4:0] func_decode_in = 0, func_irq_in = 0, func_pme_in = 0, f;
  logic [4:0] func_decode_en_out, func_irq_out, func_pme_out;
  int n_errors = 0, tests_run = 0, rst_cnt = 0, cyc = 0, nbytes, rl, t0;
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (sys_reset_out === 1'b1) rst_cnt++;
  end
  // open-drain wires with pull-ups
  assign smb_scl_in = ~smb_scl_oe_out;
  assign smb_sda_in = ~(smb_sda_oe_out | ack_oe);
  smw_top dut (.*);
  smw_lan_model lan (.scl_in(smb_scl_in), .sda_in(smb_sda_in), .ack_oe_out(ack_oe),
    .addr_out(lan_addr), .data_out(lan_data), .nbytes_out(nbytes));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic logic [4:0] gated(input logic [4:0] req, input logic [4:0] dis);
    return req & ~dis;
  endfunction : gated
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic fail(input string nm);
    n_errors++;
    $display("[ERR] %s expected done seen timeout", nm);
    print_verdict();
  endtask : fail
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_in);
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    do begin
      @(posedge clk_in);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(wr ? s_axi_bvalid : s_axi_rvalid) && n < 64);
    r = wr ? s_axi_bresp : s_axi_rresp;
    q = s_axi_rdata;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (n >= 64) fail("bus");
  endtask : bus
  function automatic logic hit(input int sel, input int goal);
    case (sel)
      0: return mgmt_interrupt_n_out === goal[0];
      1: return rst_cnt >= goal;
      2: return irq_out === goal[0];
      default: return nbytes >= 2 && !ack_oe && !smb_scl_oe_out && !smb_sda_oe_out;
    endcase
  endfunction : hit
  task automatic wait_on(input int sel, input int goal, input int lim);
    int n;
    for (n = 0; n < lim && !hit(sel, goal); n++) @(posedge clk_in);
    if (n >= lim) fail("wait");
  endtask : wait_on
  initial begin
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    bus(0, smw_pkg::BOOT_OFS, 0);
    chk("boot", q, smw_pkg::BOOT_RST);
    bus(0, smw_pkg::CTRL_OFS, 0);
    chk("ctrl", q, smw_pkg::CTRL_RST);
    bus(0, 8'h28, 0);
    chk("unmapped", r, smw_pkg::RESP_SLVERR);
    bus(1, smw_pkg::BOOT_OFS, 32'h0000_00C8);
    wait_on(1, 1, 400);
    bus(0, smw_pkg::STAT_OFS, 0);
    chk("bootfail", q[smw_pkg::ST_BOOTFAIL], 1'b1);
    chk("masked", irq_out, 1'b0);
    bus(1, smw_pkg::IEN_OFS, 32'h0000_0010);
    wait_on(2, 1, 8);
    bus(1, smw_pkg::CLR_OFS, 32'h0000_0010);
    wait_on(2, 0, 8);
    wait_on(3, 0, 60000);
    repeat (smw_pkg::SCL_QTR + 8) @(posedge clk_in);
    chk("addr", lan_addr, {smw_pkg::ALERT_ADDR, 1'b0});
    chk("code", lan_data, smw_pkg::ALERT_RST);
    bus(0, smw_pkg::STAT_OFS, 0);
    chk("sent", q[smw_pkg::ST_ALERT_DONE], 1'b1);
    first_fetch_in <= 1'b1;
    $display("boot test done");
    rl = 20 + int'(xs() & 32'h1F);
    bus(1, smw_pkg::RELOAD_OFS, rl);
    bus(1, smw_pkg::CTRL_OFS, 32'h0000_0001);
    repeat (4) begin
      repeat (rl / 2) @(posedge clk_in);
      bus(1, smw_pkg::KICK_OFS, smw_pkg::KICK_KEY);
    end
    chk("kicked", mgmt_interrupt_n_out, 1'b1);
    t0 = cyc;
    wait_on(0, 0, rl + 8);
    chk("first", cyc - t0 > rl - 2, 1'b1);
    t0 = cyc;
    wait_on(1, rst_cnt + 1, rl + 8);
    chk("second", cyc - t0 > rl - 4, 1'b1);
    bus(0, smw_pkg::STAT_OFS, 0);
    chk("expiries", q[1:0], 2'b11);
    bus(1, smw_pkg::CTRL_OFS, 0);
    bus(1, smw_pkg::CLR_OFS, 32'h0000_0003);
    wait_on(0, 1, 8);
    intruder_n_in <= 1'b0;
    wait_on(0, 0, 12);
    bus(0, smw_pkg::STAT_OFS, 0);
    chk("intrude", q[smw_pkg::ST_INTRUDE], 1'b1);
    intruder_n_in <= 1'b1;
    $display("timer test done");
    for (int i = 0; i < 9; i++) begin
      v = xs();
      f = (i == 0) ? 5'h1F : v[4:0];
      bus(1, smw_pkg::FDIS_OFS, {27'h0, f});
      bus(0, smw_pkg::FDIS_OFS, 0);
      chk("fdis", q[4:0], f);
      func_decode_in <= v[9:5];
      func_irq_in <= v[14:10];
      func_pme_in <= v[19:15];
      repeat (3) @(posedge clk_in);
      chk("decode", func_decode_en_out, gated(v[9:5], f));
      chk("irq", func_irq_out, gated(v[14:10], f));
      chk("pme", func_pme_out, gated(v[19:15], f));
    end
    $display("disable test done");
    bus(1, smw_pkg::FDIS_OFS, 0);
    bus(1, smw_pkg::CTRL_OFS, 32'h0000_0002);
    bus(1, smw_pkg::ALERT_OFS, {24'h0, v[7:0]});
    bus(1, smw_pkg::CLR_OFS, 32'h0000_003F);
    bus(1, smw_pkg::IEN_OFS, 32'h0000_0020);
    thermal_in <= 1'b1;
    wait_on(2, 1, 30000);
    bus(0, smw_pkg::STAT_OFS, 0);
    chk("thermal", q[smw_pkg::ST_THERMAL], 1'b1);
    chk("code2", lan_data, v[7:0]);
    bus(1, smw_pkg::ALERT_OFS, {24'h0, v[15:8]});
    bus(1, smw_pkg::CLR_OFS, 32'h0000_0020);
    intruder_n_in <= 1'b0;
    wait_on(2, 0, 8);
    wait_on(2, 1, 30000);
    chk("no_smi", mgmt_interrupt_n_out, 1'b1);
    chk("code3", lan_data, v[15:8]);
    $display("alert test done");
    print_verdict();
  end
endmodule : test_system_manageability_watchdog
